// [shared/bcs_pkg.sv]
package bcs_pkg;

    // instruction groups handed over by the decoder
    typedef enum logic [3:0] {
        OP_SWAP_IDX     = 4'h0,
        OP_HALT         = 4'h1,
        OP_IM_SET       = 4'h2,
        OP_STEP_R8      = 4'h3,
        OP_STEP_HL      = 4'h4,
        OP_STEP_IDXD    = 4'h5,
        OP_STEP_R16     = 4'h6,
        OP_STEP_IDX     = 4'h7,
        OP_IN_A_IMM     = 4'h8,
        OP_IN_PAGE0     = 4'h9,
        OP_IN_COUNT     = 4'ha,
        OP_IN_STEP      = 4'hb,
        OP_IN_REPEAT    = 4'hc,
        OP_DEC_BRANCH   = 4'hd,
        OP_INT_ENABLE   = 4'he
    } bcs_op_t;

    // machine cycle kinds
    typedef enum logic [2:0] {
        CK_NONE       = 3'h0,
        CK_FETCH1     = 3'h1,
        CK_FETCH2     = 3'h2,
        CK_MEM_RD     = 3'h3,
        CK_MEM_WR     = 3'h4,
        CK_PORT_RD    = 3'h5,
        CK_IDLE       = 3'h6,
        CK_IDLE_LOCK  = 3'h7
    } bcs_kind_t;

    // address sources
    typedef enum logic [3:0] {
        AS_NONE       = 4'h0,
        AS_PC         = 4'h1,
        AS_SP         = 4'h2,
        AS_SP1        = 4'h3,
        AS_HL         = 4'h4,
        AS_BC         = 4'h5,
        AS_IDXD       = 4'h6,
        AS_PORT_ACC   = 4'h7,
        AS_PORT_ZERO  = 4'h8
    } bcs_asel_t;

    // write data sources
    typedef enum logic [1:0] {
        WD_NONE    = 2'h0,
        WD_IDX_HI  = 2'h1,
        WD_IDX_LO  = 2'h2,
        WD_STEP    = 2'h3
    } bcs_wsel_t;

    typedef struct packed {
        bcs_kind_t kind;
        bcs_asel_t asel;
        bcs_wsel_t wsel;
        logic      halt;
        logic      capt_to_mem;
    } bcs_cyc_t;

    typedef struct packed {
        bcs_op_t     op;
        logic        down;
        logic        cnt_nz;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] hl;
        logic [15:0] bc;
        logic [15:0] idx;
        logic [7:0]  acc;
    } bcs_req_t;

    typedef struct packed {
        logic read_strobe_n;
        logic store_strobe_n;
        logic memory_request_n;
        logic port_request_n;
        logic first_fetch_marker_n;
        logic stopped_flag_n;
        logic fetch_start_flag_n;
    } bcs_strobe_t;

    localparam bcs_strobe_t STB_IDLE       = 7'h7f;
    localparam bcs_strobe_t STB_FETCH1     = 7'h2a;
    localparam bcs_strobe_t STB_FETCH2     = 7'h2b;
    localparam bcs_strobe_t STB_MEM_RD     = 7'h2f;
    localparam bcs_strobe_t STB_MEM_WR     = 7'h4f;
    localparam bcs_strobe_t STB_PORT_RD    = 7'h37;
    localparam bcs_strobe_t STB_HALT_FETCH = 7'h28;

    localparam logic [1:0]  ACCESS_LAST    = 2'h2;
    localparam logic [7:0]  PORT_PAGE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;
    localparam logic [7:0]  DATA_RESET     = 8'h00;

endpackage

// [src/bcs_tstate_ctr.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_tstate_ctr
    import bcs_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    input  wire logic three_state,
    output logic      done
);
    logic [1:0] cnt_ff;

    // one state per clock: access ends on the third, internal on the first
    assign done = run && (!three_state || cnt_ff == ACCESS_LAST);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_ff <= 2'h0;
        end else if (done || !run) begin
            cnt_ff <= 2'h0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end
endmodule
`default_nettype wire

// [src/bcs_strobe_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_strobe_gen
    import bcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire bcs_kind_t   kind,
    input  wire logic        halt,
    output bcs_strobe_t      strobe_ff
);
    bcs_strobe_t nxt_strobe;

    always_comb begin
        case (kind)
            CK_FETCH1:  nxt_strobe = halt ? STB_HALT_FETCH : STB_FETCH1;
            CK_FETCH2:  nxt_strobe = STB_FETCH2;
            CK_MEM_RD:  nxt_strobe = STB_MEM_RD;
            CK_MEM_WR:  nxt_strobe = STB_MEM_WR;
            CK_PORT_RD: nxt_strobe = STB_PORT_RD;
            default:    nxt_strobe = STB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strobe_ff <= STB_IDLE;
        end else begin
            strobe_ff <= nxt_strobe;
        end
    end
endmodule
`default_nettype wire

// [src/bcs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer
    import bcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        op_valid,
    input  wire bcs_req_t    op_req,
    input  wire logic [7:0]  data_in,
    input  wire logic        irq_n_pin,
    input  wire logic        busreq_n_pin,
    output logic             op_ready_ff,
    output bcs_strobe_t      strobe_ff,
    output logic [15:0]      addr_ff,
    output logic [7:0]       data_out_ff,
    output logic             data_oe_ff,
    output logic             busack_n_ff,
    output logic             irq_take_ff
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_REL  = 2'b11
    } bcs_state_t;

    bcs_state_t  state_ff;
    bcs_state_t  nxt_state;
    bcs_req_t    op_ff;
    bcs_cyc_t    cur_cyc_ff;
    bcs_cyc_t    nxt_cyc;
    logic [2:0]  step_ff;
    logic [2:0]  nxt_step;
    logic [15:0] pc_ff;
    logic [15:0] nxt_pc;
    logic [7:0]  capt_ff;
    logic [7:0]  nxt_capt;
    logic [7:0]  disp_ff;
    logic [7:0]  nxt_disp;
    logic        ret_run_ff;
    logic        irq_s1_ff;
    logic        irq_s2_ff;
    logic        breq_s1_ff;
    logic        breq_s2_ff;
    logic        take;
    logic        cyc_end;
    logic        is_last;
    logic        halt_hold;
    logic        insn_end;
    logic        grant;
    logic        is_access;
    logic        is_read;
    bcs_kind_t   show_kind;
    logic [15:0] nxt_addr;
    logic [7:0]  nxt_wdata;
    logic [15:0] idx_disp;

    function automatic bcs_cyc_t mk(bcs_kind_t k, bcs_asel_t a, bcs_wsel_t w, logic h, logic c);
        mk = '{kind: k, asel: a, wsel: w, halt: h, capt_to_mem: c};
    endfunction

    function automatic logic [2:0] len_of(bcs_op_t op, logic cnz);
        case (op)
            OP_SWAP_IDX:   len_of = 3'd7;
            OP_STEP_HL:    len_of = 3'd4;
            OP_STEP_IDXD:  len_of = 3'd0;
            OP_STEP_IDX:   len_of = 3'd3;
            OP_IN_A_IMM:   len_of = 3'd3;
            OP_IN_PAGE0:   len_of = 3'd4;
            OP_IN_COUNT:   len_of = 3'd3;
            OP_IN_STEP:    len_of = 3'd4;
            OP_IN_REPEAT:  len_of = cnz ? 3'd6 : 3'd4;
            OP_DEC_BRANCH: len_of = cnz ? 3'd5 : 3'd3;
            OP_INT_ENABLE: len_of = 3'd1;
            default:       len_of = 3'd2;
        endcase
    endfunction

    // cycle table, step by step
    function automatic bcs_cyc_t seq_of(bcs_op_t op, logic [2:0] s, logic cnz);
        bcs_cyc_t c;
        c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
        if (s == 3'd0) begin
            c = mk(CK_FETCH1, AS_PC, WD_NONE, 1'b0, 1'b0);
        end else begin
            case (op)
                OP_SWAP_IDX: begin
                    case (s)
                        3'd1:    c = mk(CK_FETCH2, AS_PC, WD_NONE, 1'b0, 1'b0);
                        3'd2:    c = mk(CK_MEM_RD, AS_SP, WD_NONE, 1'b0, 1'b0);
                        3'd3:    c = mk(CK_MEM_RD, AS_SP1, WD_NONE, 1'b0, 1'b0);
                        3'd5:    c = mk(CK_MEM_WR, AS_SP1, WD_IDX_HI, 1'b0, 1'b0);
                        3'd6:    c = mk(CK_MEM_WR, AS_SP, WD_IDX_LO, 1'b0, 1'b0);
                        default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_HALT: c = mk(CK_FETCH1, AS_PC, WD_NONE, 1'b1, 1'b0);
                OP_STEP_HL: begin
                    case (s)
                        3'd1:    c = mk(CK_MEM_RD, AS_HL, WD_NONE, 1'b0, 1'b0);
                        3'd3:    c = mk(CK_MEM_WR, AS_HL, WD_STEP, 1'b0, 1'b0);
                        default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_STEP_IDXD: begin
                    case (s)
                        3'd1:    c = mk(CK_FETCH2, AS_PC, WD_NONE, 1'b0, 1'b0);
                        3'd2:    c = mk(CK_MEM_RD, AS_PC, WD_NONE, 1'b0, 1'b0);
                        3'd5:    c = mk(CK_MEM_RD, AS_IDXD, WD_NONE, 1'b0, 1'b0);
                        3'd7:    c = mk(CK_MEM_WR, AS_IDXD, WD_STEP, 1'b0, 1'b0);
                        default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_IN_A_IMM: begin
                    case (s)
                        3'd1:    c = mk(CK_MEM_RD, AS_PC, WD_NONE, 1'b0, 1'b0);
                        default: c = mk(CK_PORT_RD, AS_PORT_ACC, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_IN_PAGE0: begin
                    case (s)
                        3'd1:    c = mk(CK_FETCH2, AS_PC, WD_NONE, 1'b0, 1'b0);
                        3'd2:    c = mk(CK_MEM_RD, AS_PC, WD_NONE, 1'b0, 1'b0);
                        default: c = mk(CK_PORT_RD, AS_PORT_ZERO, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_IN_COUNT, OP_IN_STEP, OP_IN_REPEAT: begin
                    case (s)
                        3'd1:    c = mk(CK_FETCH2, AS_PC, WD_NONE, 1'b0, 1'b0);
                        3'd2:    c = mk(CK_PORT_RD, AS_BC, WD_NONE, 1'b0, 1'b0);
                        3'd3:    c = mk(CK_MEM_WR, AS_HL, WD_NONE, 1'b0, 1'b1);
                        default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_DEC_BRANCH: begin
                    case (s)
                        3'd1:    c = mk(cnz ? CK_IDLE_LOCK : CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                        3'd2:    c = mk(CK_MEM_RD, AS_PC, WD_NONE, 1'b0, 1'b0);
                        default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                    endcase
                end
                OP_IM_SET, OP_STEP_IDX: begin
                    c = (s == 3'd1) ? mk(CK_FETCH2, AS_PC, WD_NONE, 1'b0, 1'b0)
                                    : mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
                end
                default: c = mk(CK_IDLE, AS_NONE, WD_NONE, 1'b0, 1'b0);
            endcase
        end
        seq_of = c;
    endfunction

    // asynchronous request pins pass two flip-flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_s1_ff  <= 1'b0;
            irq_s2_ff  <= 1'b0;
            breq_s1_ff <= 1'b0;
            breq_s2_ff <= 1'b0;
        end else begin
            irq_s1_ff  <= !irq_n_pin;
            irq_s2_ff  <= irq_s1_ff;
            breq_s1_ff <= !busreq_n_pin;
            breq_s2_ff <= breq_s1_ff;
        end
    end

    assign is_access = cur_cyc_ff.kind inside {CK_FETCH1, CK_FETCH2, CK_MEM_RD, CK_MEM_WR, CK_PORT_RD};
    assign is_read   = cur_cyc_ff.kind inside {CK_FETCH1, CK_FETCH2, CK_MEM_RD, CK_PORT_RD};

    bcs_tstate_ctr u_tstate (
        .clk         (clk),
        .nrst        (nrst),
        .run         (state_ff == ST_RUN),
        .three_state (is_access),
        .done        (cyc_end)
    );

    assign take      = (state_ff == ST_IDLE) && op_ready_ff && op_valid;
    assign is_last   = (step_ff == len_of(op_ff.op, op_ff.cnt_nz) - 3'd1);
    assign halt_hold = cur_cyc_ff.halt && !irq_s2_ff;
    assign insn_end  = cyc_end && is_last && !halt_hold;
    assign grant     = breq_s2_ff && ((state_ff == ST_IDLE && !take)
                     || (cyc_end && cur_cyc_ff.kind != CK_IDLE_LOCK));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = ST_RUN;
                end else if (grant) begin
                    nxt_state = ST_REL;
                end
            end
            ST_RUN: begin
                if (grant) begin
                    nxt_state = ST_REL;
                end else if (insn_end) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_REL: begin
                if (!breq_s2_ff) begin
                    nxt_state = ret_run_ff ? ST_RUN : ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_comb begin
        nxt_step = step_ff;
        nxt_cyc  = cur_cyc_ff;
        if (take) begin
            nxt_step = 3'd0;
            nxt_cyc  = seq_of(op_req.op, 3'd0, op_req.cnt_nz);
        end else if (cyc_end && !is_last) begin
            nxt_step = step_ff + 3'd1;
            nxt_cyc  = seq_of(op_ff.op, step_ff + 3'd1, op_ff.cnt_nz);
        end
    end

    // cycle bookkeeping
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff   <= ST_IDLE;
            step_ff    <= 3'd0;
            cur_cyc_ff <= mk(CK_NONE, AS_NONE, WD_NONE, 1'b0, 1'b0);
            op_ff      <= '0;
            ret_run_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            step_ff    <= nxt_step;
            cur_cyc_ff <= nxt_cyc;
            if (take) begin
                op_ff <= op_req;
            end
            if (grant && state_ff == ST_RUN) begin
                ret_run_ff <= !insn_end;
            end else if (grant) begin
                ret_run_ff <= 1'b0;
            end
        end
    end

    // program counter and captured bytes
    always_comb begin
        nxt_pc   = pc_ff;
        nxt_capt = capt_ff;
        nxt_disp = disp_ff;
        if (take) begin
            nxt_pc = op_req.pc;
        end else if (cyc_end && !cur_cyc_ff.halt && cur_cyc_ff.asel == AS_PC && is_read) begin
            nxt_pc = pc_ff + 16'h0001;
        end
        if (cyc_end && is_read) begin
            nxt_capt = data_in;
            if (cur_cyc_ff.kind == CK_MEM_RD && cur_cyc_ff.asel == AS_PC) begin
                nxt_disp = data_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc_ff   <= ADDR_RESET;
            capt_ff <= DATA_RESET;
            disp_ff <= DATA_RESET;
        end else begin
            pc_ff   <= nxt_pc;
            capt_ff <= nxt_capt;
            disp_ff <= nxt_disp;
        end
    end

    // bus drive for the cycle that starts next clock
    assign show_kind = (nxt_state == ST_RUN) ? nxt_cyc.kind : CK_NONE;
    assign idx_disp  = op_ff.idx + {{8{nxt_disp[7]}}, nxt_disp};

    always_comb begin
        case (nxt_cyc.asel)
            AS_PC:        nxt_addr = nxt_pc;
            AS_SP:        nxt_addr = op_ff.sp;
            AS_SP1:       nxt_addr = op_ff.sp + 16'h0001;
            AS_HL:        nxt_addr = op_ff.hl;
            AS_BC:        nxt_addr = op_ff.bc;
            AS_IDXD:      nxt_addr = idx_disp;
            AS_PORT_ACC:  nxt_addr = {op_ff.acc, nxt_capt};
            AS_PORT_ZERO: nxt_addr = {PORT_PAGE_ZERO, nxt_capt};
            default:      nxt_addr = addr_ff;
        endcase
        case (nxt_cyc.wsel)
            WD_IDX_HI: nxt_wdata = op_ff.idx[15:8];
            WD_IDX_LO: nxt_wdata = op_ff.idx[7:0];
            WD_STEP:   nxt_wdata = op_ff.down ? nxt_capt - 8'h01 : nxt_capt + 8'h01;
            default:   nxt_wdata = nxt_capt;
        endcase
    end

    bcs_strobe_gen u_strobe (
        .clk       (clk),
        .nrst      (nrst),
        .kind      (show_kind),
        .halt      (nxt_cyc.halt),
        .strobe_ff (strobe_ff)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_ff     <= ADDR_RESET;
            data_out_ff <= DATA_RESET;
            data_oe_ff  <= 1'b0;
            op_ready_ff <= 1'b0;
            busack_n_ff <= 1'b1;
            irq_take_ff <= 1'b0;
        end else begin
            if (show_kind != CK_NONE && show_kind != CK_IDLE && show_kind != CK_IDLE_LOCK) begin
                addr_ff <= nxt_addr;
            end
            data_out_ff <= nxt_wdata;
            data_oe_ff  <= (show_kind == CK_MEM_WR);
            op_ready_ff <= (nxt_state == ST_IDLE);
            busack_n_ff <= (nxt_state != ST_REL);
            irq_take_ff <= insn_end && irq_s2_ff && op_ff.op != OP_INT_ENABLE;
        end
    end

    // checks
    logic [1:0] age_ff;
    always_ff @(posedge clk) begin
        if (!nrst || cyc_end || state_ff != ST_RUN) begin
            age_ff <= 2'h0;
        end else begin
            age_ff <= age_ff + 2'h1;
        end
    end

    property p_fetch1;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_FETCH1 && !cur_cyc_ff.halt) |-> strobe_ff == STB_FETCH1;
    endproperty
    a_fetch1: assert property (p_fetch1) else $error("first fetch strobes wrong");

    property p_fetch2;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_FETCH2) |-> strobe_ff == STB_FETCH2;
    endproperty
    a_fetch2: assert property (p_fetch2) else $error("second fetch strobes wrong");

    property p_idle;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && !is_access) |-> (strobe_ff == STB_IDLE && !data_oe_ff);
    endproperty
    a_idle: assert property (p_idle) else $error("internal cycle drives bus");

    property p_write;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_MEM_WR) |-> (strobe_ff == STB_MEM_WR && data_oe_ff);
    endproperty
    a_write: assert property (p_write) else $error("write strobes wrong");

    property p_halt;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.halt && cyc_end && !irq_s2_ff && !breq_s2_ff)
            |=> (strobe_ff == STB_HALT_FETCH && addr_ff == $past(addr_ff));
    endproperty
    a_halt: assert property (p_halt) else $error("stop fetch not repeated");

    property p_swap_len;
        @(posedge clk) disable iff (!nrst)
        (insn_end && op_ff.op == OP_SWAP_IDX) |-> (step_ff == 3'd6 && cur_cyc_ff.asel == AS_SP);
    endproperty
    a_swap_len: assert property (p_swap_len) else $error("swap length wrong");

    property p_idxd_len;
        @(posedge clk) disable iff (!nrst)
        (insn_end && op_ff.op == OP_STEP_IDXD) |-> (step_ff == 3'd7 && addr_ff == idx_disp);
    endproperty
    a_idxd_len: assert property (p_idxd_len) else $error("indexed step length wrong");

    property p_port_acc;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_PORT_RD && op_ff.op == OP_IN_A_IMM)
            |-> (addr_ff == {op_ff.acc, capt_ff} && strobe_ff == STB_PORT_RD);
    endproperty
    a_port_acc: assert property (p_port_acc) else $error("direct port address wrong");

    property p_port_zero;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_PORT_RD && op_ff.op == OP_IN_PAGE0)
            |-> addr_ff[15:8] == PORT_PAGE_ZERO;
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("page zero upper address nonzero");

    property p_lock;
        @(posedge clk) disable iff (!nrst)
        (state_ff == ST_RUN && cur_cyc_ff.kind == CK_IDLE_LOCK) |=> busack_n_ff;
    endproperty
    a_lock: assert property (p_lock) else $error("release granted after locked state");

    property p_ei;
        @(posedge clk) disable iff (!nrst)
        (insn_end && op_ff.op == OP_INT_ENABLE) |=> !irq_take_ff;
    endproperty
    a_ei: assert property (p_ei) else $error("interrupt sampled after enable");

    property p_states;
        @(posedge clk) disable iff (!nrst)
        cyc_end |-> age_ff == (is_access ? 2'h2 : 2'h0);
    endproperty
    a_states: assert property (p_states) else $error("cycle length wrong");
endmodule
`default_nettype wire

// [verif/bcs_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_model
    import bcs_pkg::*;
(
    input  wire logic        clk,
    input  wire bcs_strobe_t strobe,
    input  wire logic [15:0] addr,
    output var  logic [7:0]  data_in
);
    // answers reads with a value tied to the address, toggles when not read
    initial data_in = 8'h00;
    always @(posedge clk) begin
        data_in <= strobe.read_strobe_n ? ~data_in : addr[7:0] ^ 8'h5a;
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
    import bcs_pkg::*;
;
    logic        clk, nrst, op_valid, irq_n_pin, busreq_n_pin;
    logic        op_ready_ff, data_oe_ff, busack_n_ff, irq_take_ff;
    bcs_req_t    op_req;
    bcs_strobe_t strobe_ff;
    logic [15:0] addr_ff;
    logic [7:0]  data_in, data_out_ff;
    logic [31:0] exp_q[$];
    int          n_mismatch, n_checks;
    bcs_sequencer dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_req(op_req), .data_in(data_in),
        .irq_n_pin(irq_n_pin), .busreq_n_pin(busreq_n_pin), .op_ready_ff(op_ready_ff), .strobe_ff(strobe_ff),
        .addr_ff(addr_ff), .data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff), .busack_n_ff(busack_n_ff),
        .irq_take_ff(irq_take_ff));
    bcs_bus_model mem (.clk(clk), .strobe(strobe_ff), .addr(addr_ff), .data_in(data_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(string what, logic [15:0] seen, logic [15:0] expv);
        n_checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task wait_ready;
        for (int i = 0; i < 40 && op_ready_ff !== 1'b1; i++) @(negedge clk);
        if (op_ready_ff !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // one letter per machine cycle: f g fetches, o operand, h stop fetch, i idle, r w p listed addresses
    // md is {down, cnt_nz}; wd holds the bytes expected on writes, first write in the top byte
    task seq(string k, bcs_op_t op, logic [1:0] md, logic [15:0] wd, logic [15:0] a0 = 16'h0, a1 = 16'h0,
             a2 = 16'h0, a3 = 16'h0);
        logic [15:0] pc;
        logic [15:0] al[4];
        bcs_strobe_t s;
        int          j;
        logic [31:0] x;
        pc = 16'h1230;
        al = '{a0, a1, a2, a3};
        j = 0;
        for (int i = 0; i < k.len(); i++) begin
            case (k[i])
                "f": s = STB_FETCH1;
                "g": s = STB_FETCH2;
                "h": s = STB_HALT_FETCH;
                "i": s = STB_IDLE;
                "w": s = STB_MEM_WR;
                "p": s = STB_PORT_RD;
                default: s = STB_MEM_RD;
            endcase
            repeat (s == STB_IDLE ? 1 : 3) exp_q.push_back({((k[i] == "w") ? wd[15:8] : 8'h00), 1'b0, s,
                ((k[i] inside {"r", "w", "p"}) ? al[j] : pc)});
            if (k[i] inside {"f", "g", "o"}) pc = pc + 16'h1;
            if (k[i] inside {"r", "w", "p"}) j++;
            if (k[i] == "w") wd = wd << 8;
        end
        wait_ready();
        @(posedge clk);
        op_valid <= 1'b1;
        op_req <= '{op:op, down:md[1], cnt_nz:md[0], pc:16'h1230, sp:16'h4ff0, hl:16'h8004, bc:16'h3c07,
                    idx:16'h2100, acc:8'h9e};
        @(posedge clk);
        op_valid <= 1'b0;
        while (exp_q.size() > 0) begin
            x = exp_q.pop_front();
            @(negedge clk);
            check("strobe", {9'h000, strobe_ff}, {9'h000, x[22:16]});
            check("data_oe", {15'h0000, data_oe_ff}, {15'h0000, x[22:16] == STB_MEM_WR});
            if (x[22:16] != STB_IDLE) check("addr", addr_ff, x[15:0]);
            if (x[22:16] == STB_MEM_WR) check("data_out", {8'h00, data_out_ff}, {8'h00, x[31:24]});
        end
        @(negedge clk);
        if (op != OP_HALT) check("end", {9'h000, strobe_ff}, {9'h000, STB_IDLE});
    endtask
    task t_swap; seq("fgrriww", OP_SWAP_IDX, 2'h0, 16'h2100, 16'h4ff0, 16'h4ff1, 16'h4ff1, 16'h4ff0); endtask
    task t_im; seq("fg", OP_IM_SET, 2'h0, 16'h0); endtask
    task t_r8; seq("fi", OP_STEP_R8, 2'h0, 16'h0); endtask
    task t_hl; seq("friw", OP_STEP_HL, 2'h2, 16'h5d00, 16'h8004, 16'h8004); endtask
    task t_idxd; seq("fgoiiriw", OP_STEP_IDXD, 2'h0, 16'h3300, 16'h2168, 16'h2168); endtask
    task t_r16; seq("fi", OP_STEP_R16, 2'h0, 16'h0); endtask
    task t_idx; seq("fgi", OP_STEP_IDX, 2'h0, 16'h0); endtask
    task t_ina; seq("fop", OP_IN_A_IMM, 2'h0, 16'h0, {8'h9e, 8'h31 ^ 8'h5a}); endtask
    task t_pg0; seq("fgop", OP_IN_PAGE0, 2'h0, 16'h0, {PORT_PAGE_ZERO, 8'h32 ^ 8'h5a}); endtask
    task t_cnt; seq("fgp", OP_IN_COUNT, 2'h0, 16'h0, 16'h3c07); endtask
    task t_step; seq("fgpw", OP_IN_STEP, 2'h0, 16'h5d00, 16'h3c07, 16'h8004); endtask
    task t_rep1; seq("fgpwii", OP_IN_REPEAT, 2'h1, 16'h5d00, 16'h3c07, 16'h8004); endtask
    task t_rep0; seq("fgpw", OP_IN_REPEAT, 2'h0, 16'h5d00, 16'h3c07, 16'h8004); endtask
    task t_ei;
        @(posedge clk);
        irq_n_pin <= 1'b0;
        seq("f", OP_INT_ENABLE, 2'h0, 16'h0);
        check("irq_take", {15'h0000, irq_take_ff}, 16'h0000);
        @(posedge clk);
        irq_n_pin <= 1'b1;
    endtask
    task t_djnz1;
        fork
            seq("fioii", OP_DEC_BRANCH, 2'h1, 16'h0);
            begin
                // request reaches the sequencer only at the end of the locked idle state
                repeat (3) @(posedge clk);
                busreq_n_pin <= 1'b0;
                @(posedge clk);
                busreq_n_pin <= 1'b1;
                repeat (3) @(negedge clk);
                check("busack_n", {15'h0000, busack_n_ff}, 16'h0001);
            end
        join
    endtask
    task t_djnz0; seq("fio", OP_DEC_BRANCH, 2'h0, 16'h0); endtask
    task t_halt;
        seq("fhh", OP_HALT, 2'h0, 16'h0);
        @(posedge clk);
        irq_n_pin <= 1'b0;
        for (int i = 0; i < 40 && irq_take_ff !== 1'b1; i++) @(negedge clk);
        check("irq_take", {15'h0000, irq_take_ff}, 16'h0001);
        if (irq_take_ff !== 1'b1) tally_and_finish();
        @(posedge clk);
        irq_n_pin <= 1'b1;
    endtask
    initial begin
        op_valid = 1'b0;
        op_req = '0;
        nrst = 1'b0;
        irq_n_pin = 1'b1;
        busreq_n_pin = 1'b1;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_swap();
        t_im();
        t_r8();
        t_hl();
        t_idxd();
        t_r16();
        t_idx();
        t_ina();
        t_pg0();
        t_cnt();
        t_step();
        t_rep1();
        t_rep0();
        t_ei();
        t_djnz1();
        t_djnz0();
        t_halt();
        wait_ready();
        tally_and_finish();
    end
endmodule
`default_nettype wire
